// file: logic/rlsc_pkg.sv
`default_nettype none
package rlsc_pkg;
    // serial framing is fixed; the bit time defaults from these but the BIT_CYC parameter overrides it
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int BIT_CYC_DEF = CLK_HZ / BAUD_RATE;
    localparam int CNT_W = 16;
    localparam int BIT_IDX_W = 3;

    localparam int CH_W = 7;
    localparam int KW_CHARS = 8;
    localparam int KW_W = CH_W * KW_CHARS;
    localparam int LEN_W = 4;
    localparam int ADDR_W = 5;
    localparam int KEY_W = 5;

    localparam logic [CH_W-1:0] CH_SEMI = 7'h3b;
    localparam logic [CH_W-1:0] CH_CR = 7'h0d;
    localparam logic [CH_W-1:0] CH_LF = 7'h0a;
    localparam logic [CH_W-1:0] CH_SP = 7'h20;
    localparam logic [CH_W-1:0] CH_TAB = 7'h09;
    localparam logic [CH_W-1:0] CH_STAR = 7'h2a;
    localparam logic [CH_W-1:0] CH_QM = 7'h3f;
    localparam logic [CH_W-1:0] CH_LOW_A = 7'h61;
    localparam logic [CH_W-1:0] CH_LOW_Z = 7'h7a;
    localparam logic [CH_W-1:0] CASE_BIT = 7'h20;

    localparam logic [CH_W-1:0] MSG_GTL = 7'h01;
    localparam logic [CH_W-1:0] MSG_LLO = 7'h11;
    localparam logic [CH_W-1:0] MSG_UNL = 7'h3f;
    localparam logic [CH_W-1:0] MLA_BASE = 7'h20;

    localparam logic [KEY_W-1:0] KEY_LOCAL = 5'h0b;

    localparam logic [KW_W-1:0] KW_REMOTE =
        {7'h52, 7'h45, 7'h4d, 7'h4f, 7'h54, 7'h45, 7'h00, 7'h00};
    localparam logic [KW_W-1:0] KW_LOCAL =
        {7'h4c, 7'h4f, 7'h43, 7'h41, 7'h4c, 7'h00, 7'h00, 7'h00};
    localparam logic [KW_W-1:0] KW_LOCKOUT =
        {7'h4c, 7'h4f, 7'h43, 7'h4b, 7'h4f, 7'h55, 7'h54, 7'h00};
    localparam logic [KW_W-1:0] KW_WAI =
        {7'h2a, 7'h57, 7'h41, 7'h49, 7'h00, 7'h00, 7'h00, 7'h00};
    localparam logic [KW_W-1:0] KW_OPC =
        {7'h2a, 7'h4f, 7'h50, 7'h43, 7'h00, 7'h00, 7'h00, 7'h00};
    localparam logic [KW_W-1:0] KW_OPCQ =
        {7'h2a, 7'h4f, 7'h50, 7'h43, 7'h3f, 7'h00, 7'h00, 7'h00};
    localparam logic [KW_W-1:0] KW_IDNQ =
        {7'h2a, 7'h49, 7'h44, 7'h4e, 7'h3f, 7'h00, 7'h00, 7'h00};

    typedef enum logic [3:0] {
        OP_LOCAL = 4'h1,
        OP_LOCAL_LOCK = 4'h2,
        OP_REMOTE = 4'h4,
        OP_REMOTE_LOCK = 4'h8
    } rlsc_op_t;

    typedef enum logic [2:0] {
        PS_COLLECT = 3'h1,
        PS_ISSUE = 3'h2,
        PS_DRAIN = 3'h4
    } rlsc_ps_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rlsc_rx_t;
endpackage : rlsc_pkg
`default_nettype wire

// file: logic/rlsc_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module rlsc_uart_rx #(
    parameter int BIT_CYC = rlsc_pkg::BIT_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic rxd,
    output logic rx_valid,
    output logic [rlsc_pkg::DATA_BITS-1:0] rx_data
);
    import rlsc_pkg::*;

    localparam logic [CNT_W-1:0] FULL = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF = CNT_W'(BIT_CYC / 2);
    localparam logic [BIT_IDX_W-1:0] LAST_BIT = BIT_IDX_W'(DATA_BITS - 1);

    logic rxd_meta_ff, rxd_s_ff;
    rlsc_rx_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [BIT_IDX_W-1:0] bit_ff, nxt_bit;
    logic [DATA_BITS-1:0] sh_ff, nxt_sh, data_ff, nxt_data;
    logic valid_ff, nxt_valid;

    // 8 data bits, 1 stop bit, no parity; a bad stop bit drops the byte
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_data = data_ff;
        nxt_valid = 1'b0;
        if (st_ff != RX_IDLE && cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end else begin
            case (st_ff)
                RX_IDLE: begin
                    if (!rxd_s_ff) begin
                        nxt_st = RX_START;
                        nxt_cnt = HALF;
                    end
                end
                RX_START: begin
                    nxt_st = rxd_s_ff ? RX_IDLE : RX_DATA;
                    nxt_cnt = FULL;
                    nxt_bit = '0;
                end
                RX_DATA: begin
                    nxt_sh = {rxd_s_ff, sh_ff[DATA_BITS-1:1]};
                    nxt_cnt = FULL;
                    nxt_bit = bit_ff + 1'b1;
                    if (bit_ff == LAST_BIT) begin
                        nxt_st = RX_STOP;
                    end
                end
                RX_STOP: begin
                    nxt_st = RX_IDLE;
                    if (rxd_s_ff) begin
                        nxt_valid = 1'b1;
                        nxt_data = sh_ff;
                    end
                end
                default: nxt_st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rxd_meta_ff <= 1'b1;
            rxd_s_ff <= 1'b1;
            st_ff <= RX_IDLE;
            cnt_ff <= '0;
            bit_ff <= '0;
            sh_ff <= '0;
            data_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            rxd_meta_ff <= rxd;
            rxd_s_ff <= rxd_meta_ff;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            data_ff <= nxt_data;
            valid_ff <= nxt_valid;
        end
    end

    assign rx_valid = valid_ff;
    assign rx_data = data_ff;
endmodule : rlsc_uart_rx
`default_nettype wire

// file: logic/rlsc_state_ctrl.sv
// Behaviour
// - four states: local or remote, each with or without lockout
// - local state passes all panel keys and runs every remote command
// - local-with-lockout acts as local but remote entry gives remote-with-lockout
// - serial remote or bus remote-enable enters remote and lights remote indicator
// - plain remote ignores all keys except the minus (local) key
// - local key, serial local or bus go-to-local return remote to local
// - serial lockout or bus lockout turns remote into remote-with-lockout, all keys ignored; from local it gives local-with-lockout
// - serial local or go-to-local moves remote-with-lockout to local-with-lockout
// - bus carries remote, local, lockout only as interface messages
// - serial text emulates only go-to-local, go-to-remote and lockout
// - keywords are case-insensitive
// - leading asterisk marks a common command, accepted on both ports
// - identification query requests the identification string
// - trailing question mark marks a query for the reply path
// - bus bytes with attention true are interface messages, else commands
// - semicolons split a line; commands issue in order
// - wait command holds later commands until overlapped work is done
// - operation-complete reports when all overlapped work is done
// - sequential commands finish before the next one issues
// - serial port defaults to 9600 baud (BIT_CYC parameter overrides it), 8 data, 1 stop, no parity
`timescale 1ns/1ps
`default_nettype none
module rlsc_state_ctrl #(
    parameter int BIT_CYC = rlsc_pkg::BIT_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ren_pin,
    input wire logic [7:0] gpib_byte,
    input wire logic gpib_atn,
    input wire logic gpib_eoi,
    input wire logic gpib_valid,
    output logic gpib_ready,
    input wire logic [rlsc_pkg::ADDR_W-1:0] my_addr,
    input wire logic ser_rxd,
    output logic xoff_req,
    input wire logic key_valid,
    input wire logic [rlsc_pkg::KEY_W-1:0] key_code,
    output logic panel_valid,
    output logic [rlsc_pkg::KEY_W-1:0] panel_code,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [rlsc_pkg::KW_W-1:0] cmd_word,
    output logic cmd_common,
    output logic cmd_query,
    output logic cmd_serial,
    input wire logic ovl_busy,
    output logic idn_req,
    output logic opc_done,
    output logic opc_query,
    output logic [3:0] op_state,
    output logic remote_indicator
);
    import rlsc_pkg::*;

    logic rx_valid;
    logic [DATA_BITS-1:0] rx_data;

    rlsc_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .rxd(ser_rxd),
        .rx_valid(rx_valid),
        .rx_data(rx_data)
    );

    // remote-enable is a bus pin: two flops before any logic reads it
    logic ren_meta_ff, ren_s_ff, ren_prev_ff;
    logic ren_rise, ren_fall;
    assign ren_rise = ren_s_ff & ~ren_prev_ff;
    assign ren_fall = ~ren_s_ff & ren_prev_ff;

    // interface messages: attention true, upper data bit ignored
    logic atn_msg, mla_ev, gtl_ev, llo_ev, unl_ev;
    logic listen_ff, nxt_listen;
    assign atn_msg = gpib_valid & gpib_atn;
    assign mla_ev = atn_msg & (gpib_byte[CH_W-1:0] == (MLA_BASE | CH_W'(my_addr)));
    assign unl_ev = atn_msg & (gpib_byte[CH_W-1:0] == MSG_UNL);
    assign gtl_ev = atn_msg & listen_ff & (gpib_byte[CH_W-1:0] == MSG_GTL);
    assign llo_ev = atn_msg & (gpib_byte[CH_W-1:0] == MSG_LLO);
    assign nxt_listen = mla_ev | (listen_ff & ~unl_ev);

    // parser state
    rlsc_ps_t ps_ff, nxt_ps;
    logic [KW_W-1:0] kw_ff, nxt_kw, word_f;
    logic [LEN_W-1:0] len_ff, nxt_len, len_f;
    logic kw_done_ff, nxt_kw_done, qm_ff, nxt_qm, qm_f;
    logic opc_pend_ff, nxt_opc_pend, opcq_pend_ff, nxt_opcq_pend;
    logic [KW_W-1:0] cw_ff, nxt_cw;
    logic cc_ff, nxt_cc, cq_ff, nxt_cq, cs_ff, nxt_cs;
    logic idn_ff, nxt_idn, opcd_ff, nxt_opcd, opcq_ff, nxt_opcq;
    logic ser_remote, ser_local, ser_lockout;

    // byte source: serial wins; bus is held off by its ready line
    logic bus_data, ch_valid, src_ser, end_ch, eoi_end, sep_ch, take;
    logic [CH_W-1:0] ch_raw, ch;
    assign gpib_ready = gpib_atn | ((ps_ff == PS_COLLECT) & ~rx_valid);
    assign bus_data = gpib_valid & ~gpib_atn & gpib_ready;
    assign src_ser = rx_valid;
    // serial bytes arriving outside collect are lost; xoff tells the host to pause
    assign ch_valid = (rx_valid | bus_data) & (ps_ff == PS_COLLECT);
    assign ch_raw = src_ser ? rx_data[CH_W-1:0] : gpib_byte[CH_W-1:0];
    assign ch = (ch_raw >= CH_LOW_A && ch_raw <= CH_LOW_Z) ? (ch_raw & ~CASE_BIT)
                                                            : ch_raw;
    assign end_ch = (ch == CH_SEMI) | (ch == CH_CR) | (src_ser & (ch == CH_LF));
    assign eoi_end = ~src_ser & gpib_eoi;
    assign sep_ch = (ch == CH_SP) | (ch == CH_TAB);
    assign take = ~end_ch & ~sep_ch & ~kw_done_ff & (len_ff < LEN_W'(KW_CHARS));
    assign xoff_req = (ps_ff != PS_COLLECT);

    function automatic logic [KW_W-1:0] kw_put(input logic [KW_W-1:0] kw,
                                              input logic [LEN_W-1:0] len,
                                              input logic [CH_W-1:0] c);
        logic [KW_W-1:0] r;
        r = kw;
        r[(KW_CHARS - 1 - int'(len)) * CH_W +: CH_W] = c;
        return r;
    endfunction : kw_put

    always_comb begin
        word_f = (ch_valid & take) ? kw_put(kw_ff, len_ff, ch) : kw_ff;
        len_f = (ch_valid & take) ? len_ff + 1'b1 : len_ff;
        qm_f = (ch_valid & take) ? (ch == CH_QM) : qm_ff;
        nxt_ps = ps_ff;
        nxt_kw = kw_ff;
        nxt_len = len_ff;
        nxt_kw_done = kw_done_ff;
        nxt_qm = qm_f;
        nxt_opc_pend = opc_pend_ff;
        nxt_opcq_pend = opcq_pend_ff;
        nxt_cw = cw_ff;
        nxt_cc = cc_ff;
        nxt_cq = cq_ff;
        nxt_cs = cs_ff;
        nxt_idn = 1'b0;
        nxt_opcd = 1'b0;
        nxt_opcq = 1'b0;
        ser_remote = 1'b0;
        ser_local = 1'b0;
        ser_lockout = 1'b0;
        case (ps_ff)
            PS_COLLECT: begin
                if (ch_valid && (end_ch || eoi_end)) begin
                    nxt_kw = '0;
                    nxt_len = '0;
                    nxt_kw_done = 1'b0;
                    nxt_qm = 1'b0;
                    if (len_f != '0) begin
                        // text forms of remote control exist on serial only
                        if (src_ser && word_f == KW_REMOTE) begin
                            ser_remote = 1'b1;
                        end else if (src_ser && word_f == KW_LOCAL) begin
                            ser_local = 1'b1;
                        end else if (src_ser && word_f == KW_LOCKOUT) begin
                            ser_lockout = 1'b1;
                        end else if (word_f == KW_WAI || word_f == KW_OPC
                                     || word_f == KW_OPCQ) begin
                            nxt_ps = PS_DRAIN;
                            nxt_opc_pend = (word_f != KW_WAI);
                            nxt_opcq_pend = (word_f == KW_OPCQ);
                        end else begin
                            nxt_ps = PS_ISSUE;
                            nxt_cw = word_f;
                            nxt_cc = (word_f[KW_W-1 -: CH_W] == CH_STAR);
                            nxt_cq = qm_f;
                            nxt_cs = src_ser;
                        end
                    end
                end else if (ch_valid && sep_ch) begin
                    nxt_kw_done = (len_ff != '0);
                end else if (ch_valid && take) begin
                    nxt_kw = word_f;
                    nxt_len = len_f;
                end
            end
            PS_ISSUE: begin
                // sequential: the next command waits for the executor
                if (cmd_ready) begin
                    nxt_ps = PS_COLLECT;
                    nxt_idn = (cw_ff == KW_IDNQ);
                end
            end
            PS_DRAIN: begin
                if (!ovl_busy) begin
                    nxt_ps = PS_COLLECT;
                    nxt_opcd = opc_pend_ff;
                    nxt_opcq = opcq_pend_ff;
                end
            end
            default: nxt_ps = PS_COLLECT;
        endcase
    end

    // operating state
    rlsc_op_t op_ff, nxt_op;
    logic ev_remote, ev_local, ev_lock, local_key;
    logic pv_ff, nxt_pv, ri_ff, nxt_ri;
    logic [KEY_W-1:0] pc_ff, nxt_pc;
    assign ev_remote = ser_remote | ren_rise | (mla_ev & ren_s_ff);
    assign ev_local = ser_local | gtl_ev;
    assign ev_lock = ser_lockout | llo_ev;
    assign local_key = key_valid & (key_code == KEY_LOCAL);

    always_comb begin
        nxt_op = op_ff;
        case (op_ff)
            OP_LOCAL: begin
                if (ev_remote) begin
                    nxt_op = OP_REMOTE;
                end else if (ev_lock) begin
                    nxt_op = OP_LOCAL_LOCK;
                end
            end
            OP_LOCAL_LOCK: begin
                if (ev_remote) begin
                    nxt_op = OP_REMOTE_LOCK;
                end else if (ser_local) begin
                    nxt_op = OP_LOCAL;
                end
            end
            OP_REMOTE: begin
                if (local_key || ev_local) begin
                    nxt_op = OP_LOCAL;
                end else if (ev_lock) begin
                    nxt_op = OP_REMOTE_LOCK;
                end
            end
            OP_REMOTE_LOCK: begin
                if (ev_local) begin
                    nxt_op = OP_LOCAL_LOCK;
                end
            end
            default: nxt_op = OP_LOCAL;
        endcase
        if (ren_fall) begin
            nxt_op = OP_LOCAL;
        end
        // keys pass only in the local states; remote swallows the local key
        nxt_pv = key_valid & (op_ff == OP_LOCAL || op_ff == OP_LOCAL_LOCK);
        nxt_pc = key_valid ? key_code : pc_ff;
        nxt_ri = (nxt_op == OP_REMOTE) || (nxt_op == OP_REMOTE_LOCK);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ren_meta_ff <= 1'b0;
            ren_s_ff <= 1'b0;
            ren_prev_ff <= 1'b0;
            listen_ff <= 1'b0;
            op_ff <= OP_LOCAL;
            pv_ff <= 1'b0;
            pc_ff <= '0;
            ri_ff <= 1'b0;
            ps_ff <= PS_COLLECT;
            kw_ff <= '0;
            len_ff <= '0;
            kw_done_ff <= 1'b0;
            qm_ff <= 1'b0;
            opc_pend_ff <= 1'b0;
            opcq_pend_ff <= 1'b0;
            cw_ff <= '0;
            cc_ff <= 1'b0;
            cq_ff <= 1'b0;
            cs_ff <= 1'b0;
            idn_ff <= 1'b0;
            opcd_ff <= 1'b0;
            opcq_ff <= 1'b0;
        end else begin
            ren_meta_ff <= ren_pin;
            ren_s_ff <= ren_meta_ff;
            ren_prev_ff <= ren_s_ff;
            listen_ff <= nxt_listen;
            op_ff <= nxt_op;
            pv_ff <= nxt_pv;
            pc_ff <= nxt_pc;
            ri_ff <= nxt_ri;
            ps_ff <= nxt_ps;
            kw_ff <= nxt_kw;
            len_ff <= nxt_len;
            kw_done_ff <= nxt_kw_done;
            qm_ff <= nxt_qm;
            opc_pend_ff <= nxt_opc_pend;
            opcq_pend_ff <= nxt_opcq_pend;
            cw_ff <= nxt_cw;
            cc_ff <= nxt_cc;
            cq_ff <= nxt_cq;
            cs_ff <= nxt_cs;
            idn_ff <= nxt_idn;
            opcd_ff <= nxt_opcd;
            opcq_ff <= nxt_opcq;
        end
    end

    assign panel_valid = pv_ff;
    assign panel_code = pc_ff;
    assign remote_indicator = ri_ff;
    assign op_state = op_ff;
    assign cmd_valid = (ps_ff == PS_ISSUE);
    assign cmd_word = cw_ff;
    assign cmd_common = cc_ff;
    assign cmd_query = cq_ff;
    assign cmd_serial = cs_ff;
    assign idn_req = idn_ff;
    assign opc_done = opcd_ff;
    assign opc_query = opcq_ff;

    a_local_keys_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (op_ff == OP_LOCAL || op_ff == OP_LOCAL_LOCK) && key_valid
        |=> panel_valid && panel_code == $past(key_code))
        else $error("panel key lost in a local state");
    a_remote_keys_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_REMOTE && key_valid |=> !panel_valid)
        else $error("panel key passed in remote");
    a_local_key_back: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_REMOTE && local_key |=> op_ff == OP_LOCAL && !remote_indicator)
        else $error("local key did not return to local");
    a_lock_keys_drop: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_REMOTE_LOCK && key_valid |=> !panel_valid && remote_indicator)
        else $error("panel key passed under lockout");
    a_lock_gtl_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_REMOTE_LOCK && gtl_ev && !ren_fall |=> op_ff == OP_LOCAL_LOCK)
        else $error("go-to-local under lockout took the wrong state");
    a_ren_drop_local: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(ren_s_ff) |=> op_ff == OP_LOCAL && !remote_indicator)
        else $error("remote-enable release did not reach local");
    a_llo_in_local: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_ff == OP_LOCAL && llo_ev && !ev_remote && !ren_fall
        |=> op_ff == OP_LOCAL_LOCK && !remote_indicator)
        else $error("lockout in local entered remote");
    a_wai_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ps_ff == PS_DRAIN && ovl_busy |=> ps_ff == PS_DRAIN && !cmd_valid)
        else $error("command issued while overlapped work pending");
    a_opc_after_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        opc_done |-> $past(ovl_busy) == 1'b0 && $past(ps_ff) == PS_DRAIN)
        else $error("operation complete reported early");
    a_issue_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word))
        else $error("issued command dropped before acceptance");
endmodule : rlsc_state_ctrl
`default_nettype wire

// file: tb/rlsc_host_uart.sv
`timescale 1ns/1ps
`default_nettype none
module rlsc_host_uart #(
    parameter int BIT_CYC = 10
) (
    input wire logic clk_sys,
    output logic txd
);
    // line rests at mark level between characters
    initial txd = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            txd <= fr[i];
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask : send
    // text stands in for the bus messages, ended by carriage return
    task automatic send_line(input string s);
        @(posedge clk_sys);
        for (int i = 0; i < s.len(); i++) begin
            send(s[i]);
        end
        send(8'h0d);
    endtask : send_line
endmodule : rlsc_host_uart
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rlsc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic ren_pin = 1'b0;
    logic [7:0] gpib_byte = 8'h00;
    logic gpib_atn = 1'b0;
    logic gpib_eoi = 1'b0;
    logic gpib_valid = 1'b0;
    logic key_valid = 1'b0;
    logic [KEY_W-1:0] key_code = 5'h00;
    logic cmd_ready = 1'b0;
    logic ovl_busy = 1'b0;
    logic ser_rxd;
    logic gpib_ready, panel_valid, cmd_valid, cmd_common, cmd_query, cmd_serial;
    logic idn_req, remote_indicator, opc_done, opc_query, xoff_req;
    logic [KEY_W-1:0] panel_code;
    logic [KW_W-1:0] cmd_word;
    logic [3:0] op_state;
    int seed = 32'hc0a74553;
    int miscompares = 0;
    int n_compared = 0;
    logic [KEY_W-1:0] k;
    int n;

    always #5 clk_sys = ~clk_sys;

    rlsc_host_uart #(.BIT_CYC(10)) host (.clk_sys(clk_sys), .txd(ser_rxd));

    rlsc_state_ctrl #(.BIT_CYC(10)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
        .ren_pin(ren_pin), .gpib_byte(gpib_byte), .gpib_atn(gpib_atn),
        .gpib_eoi(gpib_eoi), .gpib_valid(gpib_valid), .gpib_ready(gpib_ready),
        .my_addr(5'h04), .ser_rxd(ser_rxd), .xoff_req(xoff_req), .key_valid(key_valid),
        .key_code(key_code), .panel_valid(panel_valid), .panel_code(panel_code),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .cmd_common(cmd_common), .cmd_query(cmd_query), .cmd_serial(cmd_serial),
        .ovl_busy(ovl_busy), .idn_req(idn_req), .opc_done(opc_done), .opc_query(opc_query),
        .op_state(op_state), .remote_indicator(remote_indicator));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // keys reach the panel only in the two local states
    function automatic logic fwd(input logic [3:0] st);
        return st[0] | st[1];
    endfunction : fwd

    // bounded wait: serial changes land a few cycles after the stop bit
    task automatic state_is(input logic [3:0] exp);
        n = 0;
        // never look in the time step of the edge that launches the change
        @(negedge clk_sys);
        while (op_state !== exp && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check("op_state", op_state, exp);
        check("remote_indicator", remote_indicator, exp[2] | exp[3]);
    endtask : state_is

    task automatic press(input logic [KEY_W-1:0] kc);
        logic [3:0] st;
        st = op_state;
        @(posedge clk_sys);
        key_valid <= 1'b1;
        key_code <= kc;
        @(posedge clk_sys);
        key_valid <= 1'b0;
        @(negedge clk_sys);
        check("panel_valid", panel_valid, fwd(st));
        if (fwd(st)) check("panel_code", panel_code, kc);
    endtask : press

    task automatic gbyte(input logic [7:0] b, input logic atn, input logic eoi);
        @(posedge clk_sys);
        gpib_valid <= 1'b1;
        gpib_byte <= b;
        gpib_atn <= atn;
        gpib_eoi <= eoi;
        do @(negedge clk_sys); while (gpib_ready !== 1'b1);
        @(posedge clk_sys);
        gpib_valid <= 1'b0;
    endtask : gbyte

    // bus command text, the last byte carries end-or-identify
    task automatic gline(input string s);
        for (int i = 0; i < s.len(); i++) gbyte(s[i], 1'b0, i == s.len() - 1);
    endtask : gline

    // overlapped work pending: parser must hold off input until it clears
    task automatic drain(input string s, input logic opc, input logic q);
        @(posedge clk_sys);
        ovl_busy <= 1'b1;
        gline(s);
        repeat (3) begin
            @(negedge clk_sys);
            check("xoff_req", xoff_req, 1'b1);
            check("gpib_ready", gpib_ready, 1'b0);
            check("opc_done", opc_done, 1'b0);
        end
        @(posedge clk_sys);
        ovl_busy <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("opc_done", opc_done, opc);
        check("opc_query", opc_query, q);
        check("xoff_req", xoff_req, 1'b0);
    endtask : drain

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        state_is(4'h1);
        for (int i = 0; i < 6; i++) press(5'($random(seed)));
        $display("test panel done");
        gbyte(8'h11, 1'b1, 1'b0);
        state_is(4'h2);
        press(5'($random(seed)));
        @(posedge clk_sys);
        ren_pin <= 1'b1;
        state_is(4'h8);
        press(KEY_LOCAL);
        state_is(4'h8);
        host.send_line("LOCAL");
        state_is(4'h2);
        host.send_line("local");
        state_is(4'h1);
        host.send_line("rEmOtE");
        state_is(4'h4);
        for (int i = 0; i < 4; i++) begin
            k = 5'($random(seed));
            if (k == KEY_LOCAL) k = k ^ 5'h01;
            press(k);
        end
        state_is(4'h4);
        press(KEY_LOCAL);
        state_is(4'h1);
        gbyte(8'h24, 1'b1, 1'b0);
        state_is(4'h4);
        gbyte(8'h01, 1'b1, 1'b0);
        state_is(4'h1);
        host.send_line("REMOTE");
        state_is(4'h4);
        gbyte(8'h11, 1'b1, 1'b0);
        state_is(4'h8);
        gbyte(8'h3f, 1'b1, 1'b0);
        gbyte(8'h01, 1'b1, 1'b0);
        state_is(4'h8);
        gbyte(8'h24, 1'b1, 1'b0);
        gbyte(8'h01, 1'b1, 1'b0);
        state_is(4'h2);
        @(posedge clk_sys);
        ren_pin <= 1'b0;
        state_is(4'h1);
        $display("test states done");
        gline("*idn?");
        n = 0;
        while (cmd_valid !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check("cmd_word", cmd_word, KW_IDNQ);
        check("cmd_common", cmd_common, 1'b1);
        check("cmd_query", cmd_query, 1'b1);
        check("cmd_serial", cmd_serial, 1'b0);
        @(posedge clk_sys);
        cmd_ready <= 1'b1;
        @(posedge clk_sys);
        cmd_ready <= 1'b0;
        @(negedge clk_sys);
        check("idn_req", idn_req, 1'b1);
        check("cmd_valid", cmd_valid, 1'b0);
        $display("test command done");
        drain("*opc?", 1'b1, 1'b1);
        drain("*Wai", 1'b0, 1'b0);
        drain("*OPC", 1'b1, 1'b0);
        $display("test overlap done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
